// >>> rtl/acr_top.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - The select field picks oscillator divided by 2, 4, 8, 16, 32 or 64, or the internal RC clock for x11.
// - The RC conversion clock has a period of about 1.7 us, within 1 to 4 us, whatever the oscillator.
// - The done flag is set at the end of every conversion, whatever the interrupt enable holds.
// - The interrupt request is raised only while both the done flag and its enable are set.
// - The done flag stays set until software writes a one to clear it.
// - An enabled done interrupt works in normal running, and in Sleep with the RC clock only, where it wakes the device.
// - After the wake the next instruction always runs, and the service routine follows only with global enable.
// - The 10-bit result is presented left or right justified as the justify bit selects.
module acr_top
   import acr_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog converter core.
   output logic conv_busy,
   output logic conv_tick,
   input wire logic conv_done,
   input wire logic [9:0] conv_data,
   // Power management and CPU.
   input wire logic sleep_active,
   output logic irq,
   output logic wake_req,
   output logic exec_next,
   output logic isr_branch
);

   // Register and state storage.
   logic [2:0] sel_reg;
   logic [2:0] sel_next;
   logic justify_reg;
   logic justify_next;
   logic gie_reg;
   logic gie_next;
   logic flag_reg;
   logic flag_next;
   logic enable_reg;
   logic enable_next;
   logic [15:0] result_reg;
   logic [15:0] result_next;
   acr_state_t state_reg;
   acr_state_t state_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic irq_reg;
   logic irq_next;
   logic wake_reg;
   logic wake_next;
   logic exec_reg;
   logic exec_next_v;
   logic branch_reg;
   logic branch_next;
   logic tick_reg;
   logic tick_next;
   // Registered busy level for the converter core.
   logic busy_reg;
   logic busy_next;

   // Bus decode helpers.
   logic setup_phase;
   logic wr_access;
   logic mapped;
   logic wr_ctrl;
   logic wr_flag;
   logic wr_enable;
   logic start_req;
   logic done_event;
   logic div_run;
   logic rc_run;
   logic div_tick;
   logic rc_tick;

   // A transfer is decoded in its setup cycle and completes in the following access cycle.
   // A refused transfer carries pslverr, and that same flag blocks the write strobe,
   // so an error leaves every register untouched.
   assign setup_phase = psel && !penable;
   assign wr_access = psel && penable && pready_reg && pwrite && !pslverr_reg;
   assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_FLAG) || (paddr == ADDR_ENABLE)
                   || (paddr == ADDR_RESULT);
   assign wr_ctrl = wr_access && paddr == ADDR_CTRL;
   assign wr_flag = wr_access && paddr == ADDR_FLAG;
   assign wr_enable = wr_access && paddr == ADDR_ENABLE;
   assign start_req = wr_ctrl && pwdata[CTRL_START_BIT];
   // A done pulse while idle belongs to no conversion and is ignored.
   assign done_event = (state_reg == ACR_CONVERT) && conv_done;

   // The oscillator divider stops with the oscillator in Sleep; the RC source keeps going.
   assign div_run = (state_reg == ACR_CONVERT) && !acr_is_rc(sel_reg) && !sleep_active;
   assign rc_run = (state_reg == ACR_CONVERT) && acr_is_rc(sel_reg);

   // Divided oscillator conversion clock.
   acr_clkdiv u_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(div_run),
      .div(acr_div_of(sel_reg)),
      .tick(div_tick)
   );

   // Internal RC conversion clock.
   acr_rcclk u_rc (
      .pclk(pclk),
      .presetn(presetn),
      .run(rc_run),
      .tick(rc_tick)
   );

   // Control register: clock select, justification and global interrupt enable.
   always_comb begin
      sel_next = sel_reg;
      justify_next = justify_reg;
      gie_next = gie_reg;
      if (wr_ctrl) begin
         // Changing the clock mid conversion would corrupt it, so the select holds while busy.
         if (state_reg == ACR_IDLE) begin
            sel_next = pwdata[CTRL_SEL_LSB +: 3];
         end
         justify_next = pwdata[CTRL_JUSTIFY_BIT];
         // Global enable only decides whether a wake goes on to the service routine.
         gie_next = pwdata[CTRL_GIE_BIT];
      end
   end

   // Conversion sequencer: a start write begins a conversion and the core's done pulse ends it.
   // The sequencer has no timeout, so the core must always deliver its done pulse.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ACR_IDLE: begin
            if (start_req) begin
               state_next = ACR_CONVERT;
            end
         end
         ACR_CONVERT: begin
            if (conv_done) begin
               state_next = ACR_IDLE;
            end
         end
      endcase
   end

   // Result capture, laid out by the justification in force when the conversion ends.
   // Changing the justify bit during a conversion therefore affects the result being captured.
   always_comb begin
      result_next = result_reg;
      if (done_event) begin
         if (justify_reg) begin
            result_next = {6'h00, conv_data};
         end else begin
            result_next = {conv_data, 6'h00};
         end
      end
   end

   // Done flag: set by each conversion end, cleared only by a one written by software.
   // If a conversion ends in the cycle of a clear, the set wins so that no event is lost.
   always_comb begin
      flag_next = flag_reg;
      if (wr_flag && pwdata[FLAG_DONE_BIT]) begin
         flag_next = 1'b0;
      end
      if (done_event) begin
         flag_next = 1'b1;
      end
   end

   // Interrupt enable register.
   always_comb begin
      enable_next = enable_reg;
      if (wr_enable) begin
         enable_next = pwdata[ENABLE_DONE_BIT];
      end
   end

   // Interrupt level, and the wake sequence when the flag rises while the device sleeps.
   // The wake pulse marks the rising edge of the request, so one event gives one wake.
   always_comb begin
      irq_next = flag_next && enable_next;
      wake_next = 1'b0;
      exec_next_v = 1'b0;
      branch_next = 1'b0;
      if (sleep_active && irq_next && !irq_reg) begin
         wake_next = 1'b1;
      end
      // The instruction after the sleep runs first, then the vector only with global enable.
      if (wake_reg) begin
         exec_next_v = 1'b1;
      end
      if (exec_reg && gie_reg) begin
         branch_next = 1'b1;
      end
   end

   // Conversion clock enable forwarded to the core from whichever source is selected.
   // The forwarded tick lags its source by one stage; only the spacing matters to the core.
   always_comb begin
      tick_next = acr_is_rc(sel_reg) ? rc_tick : div_tick;
   end

   // Busy level taken from the next state so that it follows the sequencer exactly.
   always_comb begin
      busy_next = state_next == ACR_CONVERT;
   end

   // APB read data and completion; unmapped addresses and result writes answer with an error.
   // Zero wait states: pready is registered from the setup cycle, so every access lasts one cycle.
   always_comb begin
      prdata_next = prdata_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      if (setup_phase) begin
         pready_next = 1'b1;
         pslverr_next = !mapped || (pwrite && paddr == ADDR_RESULT);
         prdata_next = 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               ADDR_CTRL: begin
                  prdata_next[CTRL_SEL_LSB +: 3] = sel_reg;
                  prdata_next[CTRL_JUSTIFY_BIT] = justify_reg;
                  prdata_next[CTRL_GIE_BIT] = gie_reg;
                  prdata_next[CTRL_SLEEP_BIT] = sleep_active;
                  prdata_next[CTRL_BUSY_BIT] = state_reg == ACR_CONVERT;
               end
               ADDR_FLAG: prdata_next[FLAG_DONE_BIT] = flag_reg;
               ADDR_ENABLE: prdata_next[ENABLE_DONE_BIT] = enable_reg;
               ADDR_RESULT: prdata_next[15:0] = result_reg;
               default: prdata_next = 32'h0000_0000;
            endcase
         end
      end
   end

   // Registers all state of the block.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_reg <= SEL_RESET;
         justify_reg <= JUSTIFY_RESET;
         gie_reg <= GIE_RESET;
         flag_reg <= 1'b0;
         enable_reg <= 1'b0;
         result_reg <= RESULT_RESET;
         state_reg <= ACR_IDLE;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_reg <= 1'b0;
         wake_reg <= 1'b0;
         exec_reg <= 1'b0;
         branch_reg <= 1'b0;
         tick_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         sel_reg <= sel_next;
         justify_reg <= justify_next;
         gie_reg <= gie_next;
         flag_reg <= flag_next;
         enable_reg <= enable_next;
         result_reg <= result_next;
         state_reg <= state_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         irq_reg <= irq_next;
         wake_reg <= wake_next;
         exec_reg <= exec_next_v;
         branch_reg <= branch_next;
         tick_reg <= tick_next;
         busy_reg <= busy_next;
      end
   end

   // Outputs, each straight from a flip-flop.
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign conv_busy = busy_reg;
   assign conv_tick = tick_reg;
   assign irq = irq_reg;
   assign wake_req = wake_reg;
   assign exec_next = exec_reg;
   assign isr_branch = branch_reg;

endmodule // acr_top
`default_nettype wire

// >>> inc/acr_pkg.sv
`default_nettype none
package acr_pkg;

   // System oscillator, which is also the register bus clock.
   localparam int unsigned CLK_PERIOD_NS = 50;

   // Register byte addresses on APB.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FLAG = 8'h04;
   localparam logic [7:0] ADDR_ENABLE = 8'h08;
   localparam logic [7:0] ADDR_RESULT = 8'h0c;

   // Field positions of converter_control_two.
   localparam int unsigned CTRL_SEL_LSB = 0;
   localparam int unsigned CTRL_JUSTIFY_BIT = 3;
   localparam int unsigned CTRL_START_BIT = 4;
   localparam int unsigned CTRL_GIE_BIT = 5;
   localparam int unsigned CTRL_SLEEP_BIT = 7;
   localparam int unsigned CTRL_BUSY_BIT = 8;

   // Field positions of the flag and enable registers.
   localparam int unsigned FLAG_DONE_BIT = 0;
   localparam int unsigned ENABLE_DONE_BIT = 0;

   // Reset values.
   localparam logic [2:0] SEL_RESET = 3'h0;
   localparam logic JUSTIFY_RESET = 1'b0;
   localparam logic GIE_RESET = 1'b0;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // Result layout: right justified fills the low bits, left justified the high bits.
   localparam int unsigned RESULT_BITS = 10;
   localparam int unsigned LEFT_SHIFT = 16 - RESULT_BITS;

   // Internal RC conversion clock: typical period and its allowed band.
   localparam int unsigned RC_TYP_NS = 1700;
   localparam int unsigned RC_MIN_NS = 1000;
   localparam int unsigned RC_MAX_NS = 4000;
   localparam int unsigned RC_TYP_CYC = (RC_TYP_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
   localparam int unsigned RC_MIN_CYC = (RC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RC_MAX_CYC = RC_MAX_NS / CLK_PERIOD_NS;

   // Conversion sequencer states.
   typedef enum logic [0:0] {ACR_IDLE, ACR_CONVERT} acr_state_t;

   // True when the select code names the internal RC conversion clock.
   function automatic logic acr_is_rc(input logic [2:0] sel);
      return sel[1:0] == 2'b11;
   endfunction

   // Oscillator divide ratio for a select code; zero for the RC source.
   function automatic logic [6:0] acr_div_of(input logic [2:0] sel);
      logic [6:0] d;
      d = 7'h00;
      unique case (sel)
         3'b000: d = 7'h02;
         3'b100: d = 7'h04;
         3'b001: d = 7'h08;
         3'b101: d = 7'h10;
         3'b010: d = 7'h20;
         3'b110: d = 7'h40;
         3'b011, 3'b111: d = 7'h00;
      endcase
      return d;
   endfunction

endpackage
`default_nettype wire

// >>> rtl/acr_clkdiv.sv
`timescale 1ns/100ps
`default_nettype none
module acr_clkdiv
   import acr_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Control.
   input wire logic run,
   input wire logic [6:0] div,
   // Enable pulse at the divided rate.
   output logic tick
);

   logic [5:0] count_reg;
   logic [5:0] count_next;
   logic tick_reg;
   logic tick_next;

   // Counts oscillator cycles and pulses once per divide period.
   always_comb begin
      count_next = 6'h00;
      tick_next = 1'b0;
      if (run && div != 7'h00) begin
         if ({1'b0, count_reg} == div - 7'h01) begin
            tick_next = 1'b1;
         end else begin
            count_next = count_reg + 6'h01;
         end
      end
   end

   // Registers the divider state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 6'h00;
         tick_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;

endmodule // acr_clkdiv
`default_nettype wire

// >>> rtl/acr_rcclk.sv
`timescale 1ns/100ps
`default_nettype none
module acr_rcclk
   import acr_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Control.
   input wire logic run,
   // Enable pulse at the RC conversion clock rate.
   output logic tick
);

   localparam logic [6:0] PERIOD = 7'(RC_TYP_CYC);

   logic [6:0] count_reg;
   logic [6:0] count_next;
   logic tick_reg;
   logic tick_next;

   // Fixed period that does not follow the oscillator select and keeps running in Sleep.
   always_comb begin
      count_next = 7'h00;
      tick_next = 1'b0;
      if (run) begin
         if (count_reg == PERIOD - 7'h01) begin
            tick_next = 1'b1;
         end else begin
            count_next = count_reg + 7'h01;
         end
      end
   end

   // Registers the RC source state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 7'h00;
         tick_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;

endmodule // acr_rcclk
`default_nettype wire

// >>> tb/acr_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Watches tick spacing, conversion end, interrupt and wake pulses at the block's ports.
module acr_top_monitor
   import acr_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   // Converter core.
   input wire logic conv_busy,
   input wire logic conv_tick,
   input wire logic conv_done,
   // Power management and CPU.
   input wire logic sleep_active,
   input wire logic irq,
   input wire logic wake_req,
   input wire logic exec_next,
   input wire logic isr_branch
);
   logic [2:0] sel_q;
   logic [6:0] gap;
   logic had;
   wire logic [6:0] per = (sel_q[1:0] == 2'b11) ? 7'(RC_TYP_CYC) : 7'(2 << (sel_q[2] + 2 * sel_q[1:0]));

   // Tracks the select accepted while idle and the cycles since the last tick.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= 3'h0;
         gap <= 7'h00;
         had <= 1'b0;
      end else begin
         if (psel && penable && pwrite && paddr == ADDR_CTRL && !conv_busy) sel_q <= pwdata[2:0];
         gap <= conv_tick ? 7'h00 : gap + 7'h01;
         // Divided ticks pause in Sleep, so their spacing is checked afresh after it.
         had <= conv_busy && (sel_q[1:0] == 2'b11 || !sleep_active) && (had || conv_tick);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Timing and causes of tick, busy end, interrupt, wake, next-instruction and branch events.
   property p_tick_div; conv_tick && had && sel_q[1:0] != 2'b11 |-> gap == per - 7'h01; endproperty
   a_tick_div: assert property (p_tick_div) else $error("divided tick spacing wrong");
   property p_tick_rc; conv_tick && had && sel_q[1:0] == 2'b11 |-> gap == per - 7'h01; endproperty
   a_tick_rc: assert property (p_tick_rc) else $error("rc tick spacing wrong");
   property p_busy_end; $fell(conv_busy) |-> $past(conv_done); endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy ended without done");
   property p_irq_rise; $rose(irq) |-> $past(conv_busy && conv_done) || $past(psel && pwrite); endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
   property p_irq_hold; irq && !(psel && pwrite) |=> irq; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped on its own");
   property p_wake; $rose(irq) && sleep_active && $past(sleep_active) |-> wake_req; endproperty
   a_wake: assert property (p_wake) else $error("no wake in sleep");
   property p_wake_cause; wake_req |-> $rose(irq); endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake without irq rise");
   property p_exec; wake_req |=> exec_next ##1 !exec_next; endproperty
   a_exec: assert property (p_exec) else $error("next instruction pulse wrong");
   property p_isr; isr_branch |-> $past(exec_next); endproperty
   a_isr: assert property (p_isr) else $error("branch not after next instruction");
endmodule // acr_top_monitor
`default_nettype wire

// >>> tb/tb_adc_clock_irq_result_format.sv
`timescale 1ns/100ps
`default_nettype none
module tb_adc_clock_irq_result_format;
   import acr_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
   logic conv_busy, conv_tick, conv_done, sleep_active, irq, wake_req, exec_next, isr_branch;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] conv_data;
   logic [2:0] codes [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
   int n_mismatch = 0, tests_run = 0, n_wake = 0, n_exec = 0, n_isr = 0;

   acr_top uut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .conv_busy(conv_busy),
      .conv_tick(conv_tick),
      .conv_done(conv_done),
      .conv_data(conv_data),
      .sleep_active(sleep_active),
      .irq(irq),
      .wake_req(wake_req),
      .exec_next(exec_next),
      .isr_branch(isr_branch)
   );

   // Free running system clock.
   initial begin
      pclk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
   end

   // Counts the wake, next-instruction and branch pulses.
   always @(posedge pclk) begin
      if (wake_req === 1'b1) n_wake++;
      if (exec_next === 1'b1) n_exec++;
      if (isr_branch === 1'b1) n_isr++;
   end

   // Prints the counts and the verdict, then ends the run.
   task give_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task stall;
      n_mismatch++;
      $display("ERROR %0t wait ran out", $time);
      give_verdict;
   endtask

   // One APB transfer; read data and error land in rd and perr.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) stall;
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task wait_tick(output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (conv_tick !== 1'b1 && n < 200);
      if (n >= 200) stall;
   endtask

   // Starts a conversion, measures the tick period, ends it and reads the result.
   task conv(input logic [2:0] sel, input logic just, input logic [9:0] d, input logic gie);
      int n;
      apb(1'b1, ADDR_CTRL, {26'h0, gie, 1'b1, just, sel});
      chk(conv_busy, 32'h1);
      wait_tick(n);
      wait_tick(n);
      chk(n, sel[1:0] == 2'b11 ? RC_TYP_CYC : 2 << (sel[2] + 2 * sel[1:0]));
      if (sel[1:0] == 2'b11) chk(n * CLK_PERIOD_NS >= RC_MIN_NS && n * CLK_PERIOD_NS <= RC_MAX_NS, 32'h1);
      conv_done <= 1'b1;
      conv_data <= d;
      @(posedge pclk);
      conv_done <= 1'b0;
      @(posedge pclk);
      chk(conv_busy, 32'h0);
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk(rd, just ? {22'h0, d} : {16'h0, d, 6'h00});
   endtask

   // Control register reset value, an unmapped read and a refused write.
   task regs_scn;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk({rd[30:0], perr}, 32'h1);
      apb(1'b1, ADDR_RESULT, 32'hffff);
      chk(perr, 32'h1);
   endtask

   // Every select code and both layouts, flag set with the interrupt off.
   // Codes outside the recommended period range are swept here only to prove the decode.
   task sel_scn;
      for (int i = 0; i < 8; i++) begin
         conv(codes[i], i[0], 10'(10'h2a5 + i * 77), 1'b0);
         apb(1'b0, ADDR_FLAG, 32'h0);
         chk(rd, 32'h1);
         chk(irq, 32'h0);
         apb(1'b1, ADDR_FLAG, 32'h1);
      end
   endtask

   // Interrupt raised, masked, unmasked, held and cleared.
   task irq_scn;
      apb(1'b1, ADDR_ENABLE, 32'h1);
      conv(3'h6, 1'b1, 10'h155, 1'b0);
      chk(irq, 32'h1);
      apb(1'b1, ADDR_ENABLE, 32'h0);
      chk(irq, 32'h0);
      apb(1'b1, ADDR_ENABLE, 32'h1);
      repeat (10) @(posedge pclk);
      chk(irq, 32'h1);
      apb(1'b1, ADDR_FLAG, 32'h1);
      chk(irq, 32'h0);
   endtask

   // Conversion in sleep on the RC clock wakes the CPU, branching only with global enable.
   task sleep_scn;
      int w, e, b;
      sleep_active <= 1'b1;
      for (int g = 1; g >= 0; g--) begin
         w = n_wake;
         e = n_exec;
         b = n_isr;
         conv(3'h3, 1'b0, 10'h3c3, g[0]);
         repeat (3) @(posedge pclk);
         chk(n_wake - w, 32'h1);
         chk(n_exec - e, 32'h1);
         chk(n_isr - b, g);
         apb(1'b1, ADDR_FLAG, 32'h1);
      end
      sleep_active <= 1'b0;
   endtask

   // Reset for five cycles, then every scenario in turn and the verdict.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      conv_done = 1'b0;
      conv_data = 10'h000;
      sleep_active = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      regs_scn;
      sel_scn;
      irq_scn;
      sleep_scn;
      give_verdict;
   end
endmodule // tb_adc_clock_irq_result_format

bind acr_top acr_top_monitor mon (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .conv_busy(conv_busy),
   .conv_tick(conv_tick),
   .conv_done(conv_done),
   .sleep_active(sleep_active),
   .irq(irq),
   .wake_req(wake_req),
   .exec_next(exec_next),
   .isr_branch(isr_branch)
);
`default_nettype wire
